// >>> common/cpu_regs_pkg.sv
/*
 Package for the programmer-visible register set: register offsets,
 field positions, reset values and the core step command codes.
 Assumes the register port carries an 8-bit address and 8-bit data.
*/
package cpu_regs_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int RADDR_W = 8;
	localparam int PC_W = 16;
	localparam int STACK_IDX_W = 9;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] WORK_OFS = 8'h00;
	localparam logic [7:0] IDX_ONE_OFS = 8'h01;
	localparam logic [7:0] IDX_TWO_OFS = 8'h02;
	localparam logic [7:0] STACK_PTR_OFS = 8'h03;
	localparam logic [7:0] PC_LOW_OFS = 8'h04;
	localparam logic [7:0] PC_HIGH_OFS = 8'h05;
	localparam logic [7:0] STATUS_OFS = 8'h06;
	localparam logic [7:0] CPU_MODE_OFS = 8'h3B;

	// ----------------------------------------------------------------
	// Fields and page bytes
	// ----------------------------------------------------------------
	localparam int STACK_PAGE_POS = 2;
	localparam logic [7:0] PAGE_ZERO_HI = 8'h00;
	localparam logic [7:0] PAGE_ONE_HI = 8'h01;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] WORK_RST = 8'h00;
	localparam logic [7:0] IDX_RST = 8'h00;
	localparam logic [7:0] STACK_PTR_RST = 8'hFF;
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] CPU_MODE_RST = 8'h00;

	// ----------------------------------------------------------------
	// Core step commands
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NONE,
		OP_PUSH_ACCUM,
		OP_POP_ACCUM,
		OP_PUSH_STATUS_WORD,
		OP_POP_STATUS_WORD,
		OP_UNSUPPORTED_ONE,
		OP_UNSUPPORTED_TWO,
		OP_OSCILLATION_HALT,
		OP_WAIT,
		OP_PRODUCT,
		OP_QUOTIENT,
		OP_FETCH_STEP,
		OP_JUMP,
		OP_EA_INDEX_ONE,
		OP_EA_INDEX_TWO
	} op_t;

endpackage

// >>> src/stack_ram.sv
/*
 Stack memory: one write port and one read port, read data registered.
 Assumes a single clock; the memory array itself is not reset.
*/
`timescale 1ns/1ps
module stack_ram #(
	parameter int AW = 9,
	parameter int DW = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Write port
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [DW-1:0] wrData,
	// Read port
	input wire logic rdEn,
	input wire logic [AW-1:0] rdAddr,
	output logic [DW-1:0] rdData_q
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk)
	begin
		if (wrEn)
		begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rdData_q <= '0;
		end
		else if (rdEn)
		begin
			rdData_q <= mem[rdAddr];
		end
	end

endmodule

// >>> src/ea_adder.sv
/*
 Effective address adder: operand plus an 8-bit index register.
 Assumes the sum wraps within 16 bits, as an address does.
*/
`timescale 1ns/1ps
module ea_adder (
	// Operands
	input wire logic [15:0] operand,
	input wire logic [7:0] index,
	// Result
	output logic [15:0] effAddr
);

	logic [16:0] sum;

	always_comb
	begin
		sum = {1'b0, operand} + {9'h000, index};
		effAddr = sum[15:0];
	end

endmodule

// >>> src/cpu_register_set.sv
/*
 Programmer-visible register set of an 8-bit core: working register,
 two index registers, stack pointer with page select, program counter,
 status byte and CPU mode register, plus the stack and the extra
 operations that use them.
 Assumes register port and step port are driven on sys_clk; at most
 one step per cycle, accepted only while opBusy is low.
*/
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module cpu_register_set (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [7:0] regRdData_q,
	// Core step port
	input wire logic opValid,
	input wire cpu_regs_pkg::op_t opCode,
	input wire logic [15:0] opOperand,
	input wire logic wake,
	// Status towards the core
	output logic opBusy_q,
	output logic opBad_q,
	output logic haltReq_q,
	output logic waitReq_q,
	output logic [15:0] effAddr_q,
	output logic [15:0] fetchAddr_q,
	output logic [15:0] stackAddr_q
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_POP_WAIT
	} state_t;

	state_t state_q;
	logic [7:0] work_q;
	logic [7:0] idxOne_q;
	logic [7:0] idxTwo_q;
	logic [7:0] sp_q;
	logic [7:0] sp_d;
	logic [7:0] status_q;
	logic [7:0] mode_q;
	logic [7:0] mode_d;
	logic [7:0] pcLow_q;
	logic [7:0] pcHigh_q;
	logic popToWork_q;

	logic opTake;
	logic isPush;
	logic isPop;
	logic [7:0] pushData;
	logic [7:0] spInc;
	logic [7:0] spDec;
	logic [8:0] stackWrIdx;
	logic [8:0] stackRdIdx;
	logic [7:0] popData;
	logic [15:0] product;
	logic [15:0] dividend;
	logic [15:0] quotient;
	logic [15:0] remainder;
	logic divZero;
	logic [7:0] eaIndex;
	logic [15:0] eaSum;
	logic [15:0] pcNow;
	logic [15:0] pcInc;

	assign opTake = opValid && (state_q == ST_IDLE);
	assign isPush = opTake && (opCode == cpu_regs_pkg::OP_PUSH_ACCUM
		|| opCode == cpu_regs_pkg::OP_PUSH_STATUS_WORD);
	assign isPop = opTake && (opCode == cpu_regs_pkg::OP_POP_ACCUM
		|| opCode == cpu_regs_pkg::OP_POP_STATUS_WORD);

	// ----------------------------------------------------------------
	// Stack pointer and mode register
	// ----------------------------------------------------------------
	// eight-bit wrap
	assign spInc = sp_q + 8'h01;
	assign spDec = sp_q - 8'h01;

	always_comb
	begin
		sp_d = sp_q;
		if (regWrEn && regAddr == cpu_regs_pkg::STACK_PTR_OFS)
		begin
			sp_d = regWrData;
		end
		else if (isPush)
		begin
			sp_d = spDec;
		end
		else if (isPop)
		begin
			sp_d = spInc;
		end
	end

	always_comb
	begin
		mode_d = mode_q;
		if (regWrEn && regAddr == cpu_regs_pkg::CPU_MODE_OFS)
		begin
			mode_d = regWrData;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sp_q <= cpu_regs_pkg::STACK_PTR_RST;
			mode_q <= cpu_regs_pkg::CPU_MODE_RST;
			stackAddr_q <= {cpu_regs_pkg::PAGE_ZERO_HI,
				cpu_regs_pkg::STACK_PTR_RST};
		end
		else
		begin
			// pointer is the low address byte
			sp_q <= sp_d;
			mode_q <= mode_d;
			stackAddr_q <= {mode_d[cpu_regs_pkg::STACK_PAGE_POS]
				? cpu_regs_pkg::PAGE_ONE_HI
				: cpu_regs_pkg::PAGE_ZERO_HI, sp_d};
		end
	end

	// ----------------------------------------------------------------
	// Stack memory
	// ----------------------------------------------------------------
	// Page bit and pointer form the index, so wrap never leaves a page
	assign stackWrIdx = {mode_q[cpu_regs_pkg::STACK_PAGE_POS], sp_q};
	assign stackRdIdx = {mode_q[cpu_regs_pkg::STACK_PAGE_POS], spInc};
	assign pushData = (opCode == cpu_regs_pkg::OP_PUSH_ACCUM)
		? work_q : status_q;

	// push and pop move bytes through the stack
	stack_ram #(
		.AW(cpu_regs_pkg::STACK_IDX_W),
		.DW(cpu_regs_pkg::DATA_W)
	) stackMem (
		.clk(sys_clk),
		.rst_b(rst_b),
		.wrEn(isPush),
		.wrAddr(stackWrIdx),
		.wrData(pushData),
		.rdEn(isPop),
		.rdAddr(stackRdIdx),
		.rdData_q(popData)
	);

	// ----------------------------------------------------------------
	// Pop sequencing
	// ----------------------------------------------------------------
	// Read data is registered, so a pop holds the step port one cycle
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= ST_IDLE;
			popToWork_q <= 1'b0;
			opBusy_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					if (isPop)
					begin
						state_q <= ST_POP_WAIT;
						popToWork_q <= (opCode == cpu_regs_pkg::OP_POP_ACCUM);
						opBusy_q <= 1'b1;
					end
				end
				ST_POP_WAIT:
				begin
					state_q <= ST_IDLE;
					opBusy_q <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Arithmetic
	// ----------------------------------------------------------------
	// multiply and divide on the working register
	// Both factors widened so the full product is formed, not a wrapped byte
	assign product = {8'h00, work_q} * {8'h00, opOperand[7:0]};
	assign dividend = {idxOne_q, work_q};
	assign divZero = (opOperand[7:0] == 8'h00);
	// Zero divisor would be undefined; the divide then only raises opBad_q
	assign quotient = divZero ? 16'h0000
		: dividend / {8'h00, opOperand[7:0]};
	assign remainder = divZero ? 16'h0000
		: dividend % {8'h00, opOperand[7:0]};

	// ----------------------------------------------------------------
	// Working and index registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			work_q <= cpu_regs_pkg::WORK_RST;
		end
		else if (regWrEn && regAddr == cpu_regs_pkg::WORK_OFS)
		begin
			work_q <= regWrData;
		end
		else if (state_q == ST_POP_WAIT && popToWork_q)
		begin
			work_q <= popData;
		end
		else if (opTake && opCode == cpu_regs_pkg::OP_PRODUCT)
		begin
			work_q <= product[7:0];
		end
		else if (opTake && opCode == cpu_regs_pkg::OP_QUOTIENT && !divZero)
		begin
			work_q <= quotient[7:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			idxOne_q <= cpu_regs_pkg::IDX_RST;
		end
		else if (regWrEn && regAddr == cpu_regs_pkg::IDX_ONE_OFS)
		begin
			idxOne_q <= regWrData;
		end
		else if (opTake && opCode == cpu_regs_pkg::OP_PRODUCT)
		begin
			idxOne_q <= product[15:8];
		end
		else if (opTake && opCode == cpu_regs_pkg::OP_QUOTIENT && !divZero)
		begin
			idxOne_q <= remainder[7:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			idxTwo_q <= cpu_regs_pkg::IDX_RST;
		end
		else if (regWrEn && regAddr == cpu_regs_pkg::IDX_TWO_OFS)
		begin
			idxTwo_q <= regWrData;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			status_q <= cpu_regs_pkg::STATUS_RST;
		end
		else if (regWrEn && regAddr == cpu_regs_pkg::STATUS_OFS)
		begin
			status_q <= regWrData;
		end
		else if (state_q == ST_POP_WAIT && !popToWork_q)
		begin
			status_q <= popData;
		end
	end

	// ----------------------------------------------------------------
	// Effective address
	// ----------------------------------------------------------------
	assign eaIndex = (opCode == cpu_regs_pkg::OP_EA_INDEX_TWO)
		? idxTwo_q : idxOne_q;

	ea_adder eaUnit (
		.operand(opOperand),
		.index(eaIndex),
		.effAddr(eaSum)
	);

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			effAddr_q <= 16'h0000;
		end
		else if (opTake && (opCode == cpu_regs_pkg::OP_EA_INDEX_ONE
			|| opCode == cpu_regs_pkg::OP_EA_INDEX_TWO))
		begin
			effAddr_q <= eaSum;
		end
	end

	// ----------------------------------------------------------------
	// Program counter
	// ----------------------------------------------------------------
	assign pcNow = {pcHigh_q, pcLow_q};
	assign pcInc = pcNow + 16'h0001;

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pcLow_q <= cpu_regs_pkg::PC_RST[7:0];
			pcHigh_q <= cpu_regs_pkg::PC_RST[15:8];
		end
		else if (opTake && opCode == cpu_regs_pkg::OP_JUMP)
		begin
			pcLow_q <= opOperand[7:0];
			pcHigh_q <= opOperand[15:8];
		end
		else if (opTake && opCode == cpu_regs_pkg::OP_FETCH_STEP)
		begin
			pcLow_q <= pcInc[7:0];
			pcHigh_q <= pcInc[15:8];
		end
		else
		begin
			if (regWrEn && regAddr == cpu_regs_pkg::PC_LOW_OFS)
			begin
				pcLow_q <= regWrData;
			end
			if (regWrEn && regAddr == cpu_regs_pkg::PC_HIGH_OFS)
			begin
				pcHigh_q <= regWrData;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fetchAddr_q <= cpu_regs_pkg::PC_RST;
		end
		else if (opTake && opCode == cpu_regs_pkg::OP_JUMP)
		begin
			fetchAddr_q <= opOperand;
		end
		else if (opTake && opCode == cpu_regs_pkg::OP_FETCH_STEP)
		begin
			fetchAddr_q <= pcInc;
		end
		else if (regWrEn && regAddr == cpu_regs_pkg::PC_LOW_OFS)
		begin
			fetchAddr_q <= {pcHigh_q, regWrData};
		end
		else if (regWrEn && regAddr == cpu_regs_pkg::PC_HIGH_OFS)
		begin
			fetchAddr_q <= {regWrData, pcLow_q};
		end
	end

	// ----------------------------------------------------------------
	// Halt, wait and refused steps
	// ----------------------------------------------------------------
	// halt and wait requests, set wins over wake
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			haltReq_q <= 1'b0;
			waitReq_q <= 1'b0;
		end
		else
		begin
			if (opTake && opCode == cpu_regs_pkg::OP_OSCILLATION_HALT)
			begin
				haltReq_q <= 1'b1;
			end
			else if (wake)
			begin
				haltReq_q <= 1'b0;
			end
			if (opTake && opCode == cpu_regs_pkg::OP_WAIT)
			begin
				waitReq_q <= 1'b1;
			end
			else if (wake)
			begin
				waitReq_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			opBad_q <= 1'b0;
		end
		else
		begin
			opBad_q <= opTake
				&& (opCode == cpu_regs_pkg::OP_UNSUPPORTED_ONE
				|| opCode == cpu_regs_pkg::OP_UNSUPPORTED_TWO
				|| (opCode == cpu_regs_pkg::OP_QUOTIENT && divZero));
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			regRdData_q <= 8'h00;
		end
		else if (regRdEn)
		begin
			unique case (regAddr)
				cpu_regs_pkg::WORK_OFS: regRdData_q <= work_q;
				cpu_regs_pkg::IDX_ONE_OFS: regRdData_q <= idxOne_q;
				cpu_regs_pkg::IDX_TWO_OFS: regRdData_q <= idxTwo_q;
				cpu_regs_pkg::STACK_PTR_OFS: regRdData_q <= sp_q;
				cpu_regs_pkg::PC_LOW_OFS: regRdData_q <= pcLow_q;
				cpu_regs_pkg::PC_HIGH_OFS: regRdData_q <= pcHigh_q;
				cpu_regs_pkg::STATUS_OFS: regRdData_q <= status_q;
				cpu_regs_pkg::CPU_MODE_OFS: regRdData_q <= mode_q;
				default: regRdData_q <= 8'h00;
			endcase
		end
		else
		begin
			regRdData_q <= 8'h00;
		end
	end

endmodule

// >>> tb/cpu_register_set_assertions.sv
/*
 Checker for the register set, seeing only the top module's ports.
 Assumes one clock domain and the active-low asynchronous reset.
*/
`timescale 1ns/1ps
module cpu_register_set_checker (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Requests
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic opValid,
	input wire cpu_regs_pkg::op_t opCode,
	input wire logic [15:0] opOperand,
	input wire logic wake,
	// Results
	input wire logic [7:0] regRdData_q,
	input wire logic opBusy_q,
	input wire logic opBad_q,
	input wire logic haltReq_q,
	input wire logic waitReq_q,
	input wire logic [15:0] fetchAddr_q,
	input wire logic [15:0] stackAddr_q
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	logic take;
	// Bus writes are excluded: they may override the pointer
	assign take = opValid && !opBusy_q;
	// ----------------------------------------------------------------
	// Sequences
	// ----------------------------------------------------------------
	sequence pushGo_s;
		take && !regWrEn && opCode == cpu_regs_pkg::OP_PUSH_ACCUM;
	endsequence
	sequence popGo_s;
		take && !regWrEn && opCode == cpu_regs_pkg::OP_POP_ACCUM;
	endsequence
	sequence popDone_s;
		opBusy_q && stackAddr_q[7:0] == $past(stackAddr_q[7:0]) + 8'h01
		##1 !opBusy_q;
	endsequence
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	rd_idle_zero_a:
	assert property (!regRdEn |=> regRdData_q == 8'h00)
	else $error("read data not zero outside a read");
	stack_page_a:
	assert property (stackAddr_q[15:9] == 7'h00)
	else $error("stack page byte outside 00 and 01");
	push_dec_a:
	assert property (pushGo_s |=> stackAddr_q[7:0] ==
		$past(stackAddr_q[7:0]) - 8'h01 && $stable(stackAddr_q[15:8]))
	else $error("push did not step pointer down");
	pop_inc_a:
	assert property (popGo_s |=> popDone_s)
	else $error("pop did not step pointer up");
	jump_fetch_a:
	assert property (take && opCode == cpu_regs_pkg::OP_JUMP
		|=> fetchAddr_q == $past(opOperand))
	else $error("jump target not in fetch address");
	fetch_step_a:
	assert property (take && opCode == cpu_regs_pkg::OP_FETCH_STEP
		|=> fetchAddr_q == $past(fetchAddr_q) + 16'h0001)
	else $error("fetch step did not advance counter");
	bad_op_a:
	assert property (take && (opCode == cpu_regs_pkg::OP_UNSUPPORTED_ONE
		|| opCode == cpu_regs_pkg::OP_UNSUPPORTED_TWO)
		|=> opBad_q && $stable(stackAddr_q) && $stable(fetchAddr_q))
	else $error("excluded step not refused");
	halt_set_a:
	assert property (take && opCode == cpu_regs_pkg::OP_OSCILLATION_HALT
		|=> haltReq_q)
	else $error("halt step not flagged");
	wait_set_a:
	assert property (take && opCode == cpu_regs_pkg::OP_WAIT |=> waitReq_q)
	else $error("wait step not flagged");
	wake_clear_a:
	assert property (wake && !take |=> !haltReq_q && !waitReq_q)
	else $error("wake did not clear sleep flags");
endmodule

bind cpu_register_set cpu_register_set_checker u_chk (
	.sys_clk(sys_clk), .rst_b(rst_b), .regWrEn(regWrEn),
	.regRdEn(regRdEn), .opValid(opValid), .opCode(opCode),
	.opOperand(opOperand), .wake(wake), .regRdData_q(regRdData_q),
	.opBusy_q(opBusy_q), .opBad_q(opBad_q), .haltReq_q(haltReq_q),
	.waitReq_q(waitReq_q), .fetchAddr_q(fetchAddr_q),
	.stackAddr_q(stackAddr_q)
);

// >>> tb/tb.sv
/*
 Self-checking bench for the register set.
 Assumes the package is compiled first and the checker is bound.
*/
`timescale 1ns/1ps
module tb;
	logic sys_clk, rst_b, regWrEn, regRdEn, opValid, wake;
	logic [7:0] regAddr, regWrData, regRdData_q;
	cpu_regs_pkg::op_t opCode;
	logic [15:0] opOperand, effAddr_q, fetchAddr_q, stackAddr_q;
	logic opBusy_q, opBad_q, haltReq_q, waitReq_q;
	logic [3:0] stepFlags;
	int failCount = 0;
	int numChecks = 0;
	int cycles = 0;
	// Rows: address, write data, read-back value
	logic [23:0] rows [9] = '{24'h00C8C8, 24'h01A5A5, 24'h023C3C,
		24'h038080, 24'h043434, 24'h051212, 24'h068181, 24'h3B0404,
		24'h107700};
	// Reset rows: address, reset value
	logic [15:0] rstRows [8] = '{16'h00_00, 16'h01_00, 16'h02_00,
		16'h03_FF, 16'h04_00, 16'h05_00, 16'h06_00, 16'h3B_00};
	cpu_register_set u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regRdData_q(regRdData_q), .opValid(opValid),
		.opCode(opCode), .opOperand(opOperand), .wake(wake),
		.opBusy_q(opBusy_q), .opBad_q(opBad_q), .haltReq_q(haltReq_q),
		.waitReq_q(waitReq_q), .effAddr_q(effAddr_q),
		.fetchAddr_q(fetchAddr_q), .stackAddr_q(stackAddr_q));
	assign stepFlags = {opBusy_q, opBad_q, haltReq_q, waitReq_q};
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic reportAndStop;
		$display("checks %0d mismatches %0d", numChecks, failCount);
		if (failCount == 0 && numChecks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		numChecks++;
		if (g !== e)
		begin
			failCount++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge sys_clk);
		regWrEn <= 1'b0;
	endtask
	task automatic rdChk(input string nm, input logic [7:0] a,
		input logic [7:0] e);
		@(posedge sys_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge sys_clk);
		regRdEn <= 1'b0;
		#1;
		check(nm, {8'h00, e}, {8'h00, regRdData_q});
	endtask
	// Returns one ns after the edge that took the step
	task automatic step(input cpu_regs_pkg::op_t c, input logic [15:0] o);
		@(posedge sys_clk);
		opCode <= c;
		opOperand <= o;
		opValid <= 1'b1;
		@(posedge sys_clk);
		opValid <= 1'b0;
		#1;
	endtask
	// ----------------------------------------------------------------
	// Clock and timeout
	// ----------------------------------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// The whole run needs under two hundred cycles
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failCount++;
			reportAndStop;
		end
	end
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial
	begin
		{regWrEn, regRdEn, opValid, wake} = 4'h0;
		{regAddr, regWrData, opOperand} = 32'h0000_0000;
		opCode = cpu_regs_pkg::OP_NONE;
		rst_b = 1'b0;
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		#1;
		check("stack addr", 16'h00FF, stackAddr_q);
		check("fetch addr", 16'h0000, fetchAddr_q);
		check("reset flags", 16'h0000, {12'h000, stepFlags});
		check("reset ea", 16'h0000, effAddr_q);
		foreach (rstRows[i])
			rdChk("reset", rstRows[i][15:8], rstRows[i][7:0]);
		foreach (rows[i])
		begin
			wr(rows[i][23:16], rows[i][15:8]);
			rdChk("readback", rows[i][23:16], rows[i][7:0]);
		end
		check("pc halves", 16'h1234, fetchAddr_q);
		check("page one", 16'h0180, stackAddr_q);
		step(cpu_regs_pkg::OP_PUSH_ACCUM, 16'h0000);
		check("push addr", 16'h017F, stackAddr_q);
		wr(cpu_regs_pkg::WORK_OFS, 8'h00);
		step(cpu_regs_pkg::OP_POP_ACCUM, 16'h0000);
		check("pop busy", 16'h0001, {15'h0000, opBusy_q});
		check("pop addr", 16'h0180, stackAddr_q);
		rdChk("pop work", cpu_regs_pkg::WORK_OFS, 8'hC8);
		step(cpu_regs_pkg::OP_PUSH_STATUS_WORD, 16'h0000);
		wr(cpu_regs_pkg::STATUS_OFS, 8'h00);
		step(cpu_regs_pkg::OP_POP_STATUS_WORD, 16'h0000);
		rdChk("pop status", cpu_regs_pkg::STATUS_OFS, 8'h81);
		// Wrap in page zero, then a jump offered while the pop is busy
		wr(cpu_regs_pkg::STACK_PTR_OFS, 8'h00);
		wr(cpu_regs_pkg::CPU_MODE_OFS, 8'h00);
		wr(cpu_regs_pkg::WORK_OFS, 8'h5E);
		step(cpu_regs_pkg::OP_PUSH_ACCUM, 16'h0000);
		check("wrap push", 16'h00FF, stackAddr_q);
		wr(cpu_regs_pkg::WORK_OFS, 8'h00);
		@(posedge sys_clk);
		opCode <= cpu_regs_pkg::OP_POP_ACCUM;
		opValid <= 1'b1;
		@(posedge sys_clk);
		opCode <= cpu_regs_pkg::OP_JUMP;
		opOperand <= 16'hABCD;
		@(posedge sys_clk);
		opValid <= 1'b0;
		#1;
		check("busy jump", 16'h1234, fetchAddr_q);
		check("wrap pop", 16'h0000, stackAddr_q);
		rdChk("wrap work", cpu_regs_pkg::WORK_OFS, 8'h5E);
		step(cpu_regs_pkg::OP_JUMP, 16'hABCD);
		check("jump", 16'hABCD, fetchAddr_q);
		step(cpu_regs_pkg::OP_FETCH_STEP, 16'h0000);
		check("fetch step", 16'hABCE, fetchAddr_q);
		rdChk("pc low", cpu_regs_pkg::PC_LOW_OFS, 8'hCE);
		step(cpu_regs_pkg::OP_EA_INDEX_ONE, 16'h1000);
		check("ea one", 16'h10A5, effAddr_q);
		step(cpu_regs_pkg::OP_EA_INDEX_TWO, 16'h00FF);
		check("ea two", 16'h013B, effAddr_q);
		wr(cpu_regs_pkg::WORK_OFS, 8'hC8);
		step(cpu_regs_pkg::OP_PRODUCT, 16'h000A);
		rdChk("prod low", cpu_regs_pkg::WORK_OFS, 8'hD0);
		rdChk("prod high", cpu_regs_pkg::IDX_ONE_OFS, 8'h07);
		wr(cpu_regs_pkg::WORK_OFS, 8'hD3);
		step(cpu_regs_pkg::OP_QUOTIENT, 16'h000A);
		rdChk("quotient", cpu_regs_pkg::WORK_OFS, 8'hC8);
		rdChk("remainder", cpu_regs_pkg::IDX_ONE_OFS, 8'h03);
		step(cpu_regs_pkg::OP_QUOTIENT, 16'h0000);
		check("div zero", 16'h0001, {15'h0000, opBad_q});
		rdChk("div kept", cpu_regs_pkg::WORK_OFS, 8'hC8);
		step(cpu_regs_pkg::OP_UNSUPPORTED_ONE, 16'h0000);
		check("bad one", 16'h0001, {15'h0000, opBad_q});
		step(cpu_regs_pkg::OP_UNSUPPORTED_TWO, 16'h0000);
		check("bad two", 16'h0001, {15'h0000, opBad_q});
		step(cpu_regs_pkg::OP_OSCILLATION_HALT, 16'h0000);
		check("halt", 16'h0002, {14'h0000, haltReq_q, waitReq_q});
		step(cpu_regs_pkg::OP_WAIT, 16'h0000);
		check("wait", 16'h0003, {14'h0000, haltReq_q, waitReq_q});
		@(posedge sys_clk);
		wake <= 1'b1;
		@(posedge sys_clk);
		wake <= 1'b0;
		#1;
		check("wake", 16'h0000, {14'h0000, haltReq_q, waitReq_q});
		// Reset in mid-run must clear flags and pointers at once
		step(cpu_regs_pkg::OP_OSCILLATION_HALT, 16'h0000);
		@(posedge sys_clk);
		rst_b <= 1'b0;
		#1;
		check("mid flags", 16'h0000, {12'h000, stepFlags});
		check("mid stack", 16'h00FF, stackAddr_q);
		check("mid fetch", 16'h0000, fetchAddr_q);
		check("mid ea", 16'h0000, effAddr_q);
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		rdChk("mid sp", cpu_regs_pkg::STACK_PTR_OFS, 8'hFF);
		reportAndStop;
	end
endmodule
